// >>> hw/psi_latch.sv
`timescale 1ns/1ps
module psi_latch #(
    parameter logic ACTIVE = 1'b1,
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic event_i,
    input wire logic clear_i,
    output logic q_o
);
    // Event wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            q_o <= RESET_VAL;
        end else if (event_i) begin
            q_o <= ACTIVE;
        end else if (clear_i) begin
            q_o <= ~ACTIVE;
        end
    end
endmodule

// >>> hw/psi_pkg.sv
package psi_pkg;

    // Management register addresses
    localparam logic [4:0] PSI_ADDR_STATUS = 5'h01;
    localparam logic [4:0] PSI_ADDR_ID_HIGH = 5'h02;
    localparam logic [4:0] PSI_ADDR_ID_LOW = 5'h03;

    // Management frame opcodes and field counts
    localparam logic [1:0] PSI_OP_READ = 2'h2;
    localparam logic [1:0] PSI_OP_WRITE = 2'h1;
    localparam logic [5:0] PSI_PREAMBLE_BITS = 6'h20;
    localparam logic [3:0] PSI_HDR_LAST = 4'hb;
    localparam logic [3:0] PSI_DATA_LAST = 4'hf;

    // Status register field positions
    localparam int PSI_BS_T4 = 15;
    localparam int PSI_BS_TX_FD = 14;
    localparam int PSI_BS_TX_HD = 13;
    localparam int PSI_BS_10_FD = 12;
    localparam int PSI_BS_10_HD = 11;
    localparam int PSI_BS_RSV_HI = 10;
    localparam int PSI_BS_RSV_LO = 7;
    localparam int PSI_BS_PRE_SKIP = 6;
    localparam int PSI_BS_AN_DONE = 5;
    localparam int PSI_BS_RFAULT = 4;
    localparam int PSI_BS_AN_ABLE = 3;
    localparam int PSI_BS_LINK = 2;
    localparam int PSI_BS_JABBER = 1;
    localparam int PSI_BS_EXT = 0;

    // Second identifier register field positions
    localparam int PSI_ID_VEND_LSB = 10;
    localparam int PSI_ID_MODEL_LSB = 4;

    // Identity defaults, values are arbitrary
    localparam logic [15:0] PSI_VENDOR_UPPER_DEF = 16'h5a3c;
    localparam logic [5:0] PSI_VENDOR_LOWER_DEF = 6'h15;
    localparam logic [5:0] PSI_MODEL_DEF = 6'h0a;
    localparam logic [3:0] PSI_REVISION_DEF = 4'h1;

    // Latch slots: 0 remote fault, 1 jabber, 2 link
    localparam int PSI_LATCHES = 3;
    localparam logic [2:0] PSI_LATCH_ACTIVE = 3'h3;
    localparam logic [2:0] PSI_LATCH_RESET = 3'h0;

    typedef struct packed {
        logic an_complete;
        logic far_end_fault;
        logic lp_remote_fault;
        logic link_good;
        logic jabber;
        logic speed_10;
    } psi_status_in_type;

    typedef struct packed {
        logic [1:0] op;
        logic [4:0] phyad;
        logic [4:0] regad;
    } psi_header_type;

    typedef enum logic [2:0] {
        PSI_IDLE = 3'b000,
        PSI_START = 3'b001,
        PSI_HDR = 3'b010,
        PSI_TA = 3'b011,
        PSI_DATA = 3'b100
    } psi_state_type;

endpackage

// >>> hw/psi_status_regs.sv
`timescale 1ns/1ps
// How it works
// - status bit 15 reads fixed 0, no 100BASE-T4 mode.
// - status bits 14 to 11 read fixed 1, the four speed/duplex abilities.
// - status bits 10 to 7 read zero; controller writes zero there.
// - bit 6 reads 1; 32 preamble ones needed after reset, bad opcode or bad write turnaround.
// - bit 5 shows auto-negotiation complete, live from the input, no reset value.
// - bit 4 latches high on far end fault or partner remote fault.
// - latched remote fault clears on status read or reset.
// - bit 3 reads fixed 1, auto-negotiation supported.
// - bit 2 is link valid, 0 from reset, any failure latches it low.
// - link bit returns high only with good link after a status read.
// - bit 1 is jabber, meaningful only at 10 Mbps, 0 from reset.
// - jabber latches high until a status read or reset.
// - bit 0 reads fixed 1, extended registers present.
// - 32-bit identifier spans two registers: vendor, model, revision.
// - first identifier register holds vendor bits 3 to 18 in bits 15:0.
// - identifier may legally read as all zero.
// - status decoded at address 0x01, first identifier at 0x02.
// - second identifier at 0x03: vendor 19-24, model 9:4, revision 3:0.
module psi_status_regs
    import psi_pkg::*;
#(
    parameter logic [15:0] VENDOR_UPPER = PSI_VENDOR_UPPER_DEF,
    parameter logic [5:0] VENDOR_LOWER = PSI_VENDOR_LOWER_DEF,
    parameter logic [5:0] MODEL = PSI_MODEL_DEF,
    parameter logic [3:0] REVISION = PSI_REVISION_DEF
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    input wire logic [4:0] phy_addr_i,
    input wire psi_status_in_type status_i,
    output logic mdio_o,
    output logic mdio_oe_o
);

    // Synchronised management pins
    logic mdc_s;
    logic mdio_s;
    logic mdc_d;
    logic mdc_rise;

    // Frame state
    psi_state_type state;
    psi_state_type next_state;
    psi_header_type hdr;
    psi_header_type next_hdr;
    psi_header_type hdr_shift;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [5:0] ones_cnt;
    logic need_pre;
    logic next_need_pre;
    logic [15:0] data_sr;
    logic [15:0] next_data_sr;
    logic next_mdio_o;
    logic next_mdio_oe;
    logic read_done;
    logic next_read_done;

    // Decode wires
    logic op_ok;
    logic is_read;
    logic for_us;
    logic drive_rd;
    logic pre_ok;
    logic ta_bad;
    logic hdr_last;
    logic data_last;
    logic [15:0] read_word;
    logic [15:0] status_word;

    // Latching status bits
    logic [PSI_LATCHES-1:0] latch_event;
    logic [PSI_LATCHES-1:0] latched;
    logic rf_evt;
    logic jab_evt;
    logic link_fail;

    // Builds the status word from live and latched bits
    function automatic logic [15:0] make_status(
        input logic an_done,
        input logic rfault,
        input logic link,
        input logic jabber
    );
        logic [15:0] w;
        w = 16'h0000;
        w[PSI_BS_T4] = 1'b0;
        w[PSI_BS_TX_FD] = 1'b1;
        w[PSI_BS_TX_HD] = 1'b1;
        w[PSI_BS_10_FD] = 1'b1;
        w[PSI_BS_10_HD] = 1'b1;
        w[PSI_BS_RSV_HI:PSI_BS_RSV_LO] = 4'h0;
        w[PSI_BS_PRE_SKIP] = 1'b1;
        w[PSI_BS_AN_DONE] = an_done;
        w[PSI_BS_RFAULT] = rfault;
        w[PSI_BS_AN_ABLE] = 1'b1;
        w[PSI_BS_LINK] = link;
        w[PSI_BS_JABBER] = jabber;
        w[PSI_BS_EXT] = 1'b1;
        return w;
    endfunction

    // Register read decode, unmapped addresses read zero
    function automatic logic [15:0] read_value(
        input logic [4:0] regad,
        input logic [15:0] status
    );
        logic [15:0] v;
        v = 16'h0000;
        case (regad)
            PSI_ADDR_STATUS: v = status;
            PSI_ADDR_ID_HIGH: v = VENDOR_UPPER;
            PSI_ADDR_ID_LOW: begin
                v[15:PSI_ID_VEND_LSB] = VENDOR_LOWER;
                v[PSI_ID_VEND_LSB-1:PSI_ID_MODEL_LSB] = MODEL;
                v[PSI_ID_MODEL_LSB-1:0] = REVISION;
            end
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // Both management pins cross into the system clock
    psi_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .async_i({mdc_i, mdio_i}),
        .sync_o({mdc_s, mdio_s})
    );

    // Latch events; jabber counts only at 10 Mbps
    assign rf_evt = status_i.far_end_fault | status_i.lp_remote_fault;
    assign jab_evt = status_i.jabber & status_i.speed_10;
    assign link_fail = ~status_i.link_good;
    assign latch_event = {link_fail, jab_evt, rf_evt};

    // One latch per sticky bit, all cleared by a finished status read
    generate
        for (genvar i = 0; i < PSI_LATCHES; i++) begin : g_latch
            psi_latch #(
                .ACTIVE(PSI_LATCH_ACTIVE[i]),
                .RESET_VAL(PSI_LATCH_RESET[i])
            ) u_latch (
                .clk_sys_i(clk_sys_i),
                .reset_i(reset_i),
                .event_i(latch_event[i]),
                .clear_i(read_done),
                .q_o(latched[i])
            );
        end
    endgenerate

    // Register contents
    assign status_word = make_status(status_i.an_complete, latched[0], latched[2], latched[1]);
    assign read_word = read_value(hdr.regad, status_word);

    // Frame decode
    assign mdc_rise = mdc_s & ~mdc_d;
    assign hdr_shift = psi_header_type'({hdr[10:0], mdio_s});
    assign op_ok = (hdr_shift.op == PSI_OP_READ) || (hdr_shift.op == PSI_OP_WRITE);
    assign is_read = (hdr.op == PSI_OP_READ);
    assign for_us = (hdr.phyad == phy_addr_i);
    assign drive_rd = is_read & for_us;
    assign pre_ok = ~need_pre | (ones_cnt == PSI_PREAMBLE_BITS);
    assign ta_bad = ~is_read & ((bit_cnt == 4'h0) ? ~mdio_s : mdio_s);
    assign hdr_last = (bit_cnt == PSI_HDR_LAST);
    assign data_last = (bit_cnt == PSI_DATA_LAST);

    // Frame sequencer, steps once per rising management clock
    always_comb begin
        next_state = state;
        next_hdr = hdr;
        next_bit_cnt = bit_cnt;
        next_need_pre = need_pre;
        next_data_sr = data_sr;
        next_mdio_o = mdio_o;
        next_mdio_oe = mdio_oe_o;
        next_read_done = 1'b0;
        if (mdc_rise) begin
            case (state)
                PSI_IDLE: begin
                    if (!mdio_s && pre_ok) begin
                        next_state = PSI_START;
                    end
                end
                PSI_START: begin
                    if (mdio_s) begin
                        next_state = PSI_HDR;
                        next_bit_cnt = 4'h0;
                        next_need_pre = 1'b0;
                    end else begin
                        next_state = PSI_IDLE;
                    end
                end
                PSI_HDR: begin
                    next_hdr = hdr_shift;
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (hdr_last && !op_ok) begin
                        next_state = PSI_IDLE;
                        next_need_pre = 1'b1;
                    end else if (hdr_last) begin
                        next_state = PSI_TA;
                        next_bit_cnt = 4'h0;
                    end
                end
                PSI_TA: begin
                    if (ta_bad) begin
                        next_state = PSI_IDLE;
                        next_need_pre = 1'b1;
                    end else if (bit_cnt == 4'h0) begin
                        next_bit_cnt = 4'h1;
                        next_mdio_oe = drive_rd;
                        next_mdio_o = 1'b0;
                    end else begin
                        next_state = PSI_DATA;
                        next_bit_cnt = 4'h0;
                        if (drive_rd) begin
                            next_mdio_o = read_word[15];
                            next_data_sr = {read_word[14:0], 1'b0};
                        end
                    end
                end
                PSI_DATA: begin
                    next_bit_cnt = bit_cnt + 4'h1;
                    next_mdio_o = data_sr[15];
                    next_data_sr = {data_sr[14:0], 1'b0};
                    if (data_last) begin
                        next_state = PSI_IDLE;
                        next_mdio_oe = 1'b0;
                        next_mdio_o = 1'b0;
                        next_read_done = drive_rd && (hdr.regad == PSI_ADDR_STATUS);
                    end
                end
                default: begin
                    next_state = PSI_IDLE;
                    next_mdio_oe = 1'b0;
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state <= PSI_IDLE;
            hdr <= '0;
            bit_cnt <= 4'h0;
            need_pre <= 1'b1;
            data_sr <= 16'h0000;
            mdio_o <= 1'b0;
            mdio_oe_o <= 1'b0;
            read_done <= 1'b0;
        end else begin
            state <= next_state;
            hdr <= next_hdr;
            bit_cnt <= next_bit_cnt;
            need_pre <= next_need_pre;
            data_sr <= next_data_sr;
            mdio_o <= next_mdio_o;
            mdio_oe_o <= next_mdio_oe;
            read_done <= next_read_done;
        end
    end

    // Edge detect and saturating preamble count
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            mdc_d <= 1'b0;
            ones_cnt <= 6'h00;
        end else begin
            mdc_d <= mdc_s;
            if (mdc_rise) begin
                ones_cnt <= !mdio_s ? 6'h00 :
                    (ones_cnt == PSI_PREAMBLE_BITS) ? ones_cnt : ones_cnt + 6'h01;
            end
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    // Status read drives 0 first on the pin
    property p_t4_zero;
        (state == PSI_TA && bit_cnt == 4'h1 && mdc_rise && !ta_bad && drive_rd
            && hdr.regad == PSI_ADDR_STATUS) |=> (mdio_oe_o && !mdio_o);
    endproperty
    a_t4_zero: assert property (p_t4_zero)
        else $error("status bit 15 not driven as zero");

    property p_abilities;
        status_word[PSI_BS_TX_FD:PSI_BS_10_HD] == 4'hf && status_word[PSI_BS_AN_ABLE]
            && status_word[PSI_BS_EXT];
    endproperty
    a_abilities: assert property (p_abilities)
        else $error("fixed ability bits wrong");

    property p_reserved;
        status_word[PSI_BS_RSV_HI:PSI_BS_RSV_LO] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved status bits not zero");

    // Short preamble start is refused while preamble is owed
    property p_preamble;
        (state == PSI_IDLE && mdc_rise && !mdio_s && need_pre
            && ones_cnt != PSI_PREAMBLE_BITS) |=> (state == PSI_IDLE);
    endproperty
    a_preamble: assert property (p_preamble)
        else $error("frame accepted without preamble");

    property p_an_done;
        status_word[PSI_BS_AN_DONE] == status_i.an_complete;
    endproperty
    a_an_done: assert property (p_an_done)
        else $error("auto-negotiation bit mismatch");

    // Held a second cycle unless a finished read cleared it
    property p_rf_set;
        rf_evt |=> status_word[PSI_BS_RFAULT]
            ##1 (status_word[PSI_BS_RFAULT] || $past(read_done));
    endproperty
    a_rf_set: assert property (p_rf_set)
        else $error("remote fault not latched");

    property p_rf_clear;
        (read_done && !rf_evt) |=> !latched[0];
    endproperty
    a_rf_clear: assert property (p_rf_clear)
        else $error("remote fault not cleared by read");

    property p_link_fail;
        link_fail |=> !status_word[PSI_BS_LINK];
    endproperty
    a_link_fail: assert property (p_link_fail)
        else $error("link failure not latched low");

    property p_link_rearm;
        $rose(latched[2]) |-> $past(read_done) && $past(status_i.link_good);
    endproperty
    a_link_rearm: assert property (p_link_rearm)
        else $error("link bit set without read");

    property p_jab_speed;
        (!latched[1] && !(status_i.jabber && status_i.speed_10)) |=> !latched[1];
    endproperty
    a_jab_speed: assert property (p_jab_speed)
        else $error("jabber set outside 10 Mbps");

    property p_jab_hold;
        (latched[1] && !read_done) |=> latched[1];
    endproperty
    a_jab_hold: assert property (p_jab_hold)
        else $error("jabber dropped without read");

    property p_id_high;
        read_value(PSI_ADDR_ID_HIGH, status_word) == VENDOR_UPPER;
    endproperty
    a_id_high: assert property (p_id_high)
        else $error("identifier high wrong");

    property p_write_quiet;
        (state == PSI_DATA && !is_read) |-> (!mdio_oe_o && !next_read_done);
    endproperty
    a_write_quiet: assert property (p_write_quiet)
        else $error("write frame disturbed registers");

endmodule

// >>> hw/psi_sync.sv
`timescale 1ns/1ps
module psi_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    // Two flops, first stage read only by the second
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule

// >>> test/phy_status_id_registers_bench.sv
`timescale 1ns/1ps
module phy_status_id_registers_bench;
    import psi_pkg::*;
    localparam logic [4:0] MY_ADDR = 5'h05;
    localparam logic [15:0] ID_LOW = {PSI_VENDOR_LOWER_DEF, PSI_MODEL_DEF, PSI_REVISION_DEF};
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic mdc;
    logic mdio;
    logic dut_mdio;
    logic dut_oe;
    logic sta_drv;
    logic sta_dat;
    psi_status_in_type st = '0;
    logic [15:0] rd;
    int err_total = 0;
    int n_compared = 0;

    // Clock and resolved line with pull-up
    always #4 clk_sys_i = ~clk_sys_i;
    assign mdio = dut_oe ? dut_mdio : (sta_drv ? sta_dat : 1'b1);

    psi_status_regs i_dut (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .mdc_i(mdc),
        .mdio_i(mdio),
        .phy_addr_i(MY_ADDR),
        .status_i(st),
        .mdio_o(dut_mdio),
        .mdio_oe_o(dut_oe)
    );

    psi_sta_model i_sta (
        .mdio_i(mdio),
        .mdc_o(mdc),
        .drv_o(sta_drv),
        .dat_o(sta_dat)
    );

    // Expected status word from the variable bits
    function automatic logic [15:0] exp_st(input logic an, rf, lk, jb);
        return {1'b0, 4'hf, 4'h0, 1'b1, an, rf, 1'b1, lk, jb, 1'b1};
    endfunction

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_reg(input logic pre, input logic [4:0] ra, output logic [15:0] d);
        i_sta.frame(pre, PSI_OP_READ, MY_ADDR, ra, 16'h0000, d);
    endtask

    // Toggle status inputs for one clock cycle
    task automatic pulse(input logic [5:0] m);
        @(posedge clk_sys_i);
        #1 st = psi_status_in_type'(st ^ m);
        @(posedge clk_sys_i);
        #1 st = psi_status_in_type'(st ^ m);
        repeat (4) @(posedge clk_sys_i);
    endtask

    task automatic t_reset_values();
        rd_reg(1'b1, PSI_ADDR_STATUS, rd);
        check("status after reset", exp_st(0, 0, 0, 0), rd);
        check("status bit 6", 16'h0040, rd & 16'h0040);
    endtask

    task automatic t_identity();
        rd_reg(1'b0, PSI_ADDR_ID_HIGH, rd);
        check("identifier high", PSI_VENDOR_UPPER_DEF, rd);
        rd_reg(1'b0, PSI_ADDR_ID_LOW, rd);
        check("identifier low", ID_LOW, rd);
        rd_reg(1'b0, 5'h07, rd);
        check("unmapped read", 16'h0000, rd);
    endtask

    task automatic t_remote_fault();
        logic [5:0] src [2];
        src = '{6'h10, 6'h08};
        foreach (src[k]) begin
            pulse(src[k]);
            rd_reg(1'b0, PSI_ADDR_STATUS, rd);
            check("remote fault set", exp_st(0, 1, 0, 0), rd);
            rd_reg(1'b0, PSI_ADDR_STATUS, rd);
            check("remote fault cleared", exp_st(0, 0, 0, 0), rd);
        end
    endtask

    task automatic t_jabber();
        @(posedge clk_sys_i);
        #1 st.speed_10 = 1'b1;
        pulse(6'h02);
        rd_reg(1'b0, PSI_ADDR_STATUS, rd);
        check("jabber set", exp_st(0, 0, 0, 1), rd);
        rd_reg(1'b0, PSI_ADDR_STATUS, rd);
        check("jabber cleared", exp_st(0, 0, 0, 0), rd);
        @(posedge clk_sys_i);
        #1 st.speed_10 = 1'b0;
        pulse(6'h02);
        rd_reg(1'b0, PSI_ADDR_STATUS, rd);
        check("jabber at 100", exp_st(0, 0, 0, 0), rd);
    endtask

    task automatic t_link();
        @(posedge clk_sys_i);
        #1 st.link_good = 1'b1;
        st.an_complete = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        rd_reg(1'b0, PSI_ADDR_STATUS, rd);
        check("link still low", exp_st(1, 0, 0, 0), rd);
        rd_reg(1'b0, PSI_ADDR_STATUS, rd);
        check("link up after read", exp_st(1, 0, 1, 0), rd);
        pulse(6'h04);
        rd_reg(1'b0, PSI_ADDR_STATUS, rd);
        check("link drop latched", exp_st(1, 0, 0, 0), rd);
        @(posedge clk_sys_i);
        #1 st.an_complete = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        rd_reg(1'b0, PSI_ADDR_STATUS, rd);
        check("link back, an low", exp_st(0, 0, 1, 0), rd);
    endtask

    task automatic t_write_ignored();
        @(posedge clk_sys_i);
        #1 st.speed_10 = 1'b1;
        pulse(6'h02);
        i_sta.frame(1'b0, PSI_OP_WRITE, MY_ADDR, PSI_ADDR_STATUS, 16'hffff, rd);
        i_sta.frame(1'b0, PSI_OP_WRITE, MY_ADDR, PSI_ADDR_ID_HIGH, 16'h0000, rd);
        rd_reg(1'b0, PSI_ADDR_STATUS, rd);
        check("status after write", exp_st(0, 0, 1, 1), rd);
        rd_reg(1'b0, PSI_ADDR_ID_HIGH, rd);
        check("id after write", PSI_VENDOR_UPPER_DEF, rd);
    endtask

    task automatic t_bad_frame();
        i_sta.frame(1'b0, MY_ADDR == 5'h00 ? 2'b11 : 2'b00, MY_ADDR, PSI_ADDR_STATUS, 16'h0, rd);
        rd_reg(1'b0, PSI_ADDR_STATUS, rd);
        check("read with preamble owed", 16'hffff, rd);
        rd_reg(1'b1, PSI_ADDR_STATUS, rd);
        check("read after preamble", exp_st(0, 0, 1, 0), rd);
        // Write with a broken turnaround owes the preamble again
        i_sta.frame_ta(1'b0, PSI_OP_WRITE, MY_ADDR, PSI_ADDR_STATUS, 2'b00, 16'h0, rd);
        rd_reg(1'b0, PSI_ADDR_STATUS, rd);
        check("read after bad turnaround", 16'hffff, rd);
        rd_reg(1'b1, PSI_ADDR_STATUS, rd);
        check("read after second preamble", exp_st(0, 0, 1, 0), rd);
        i_sta.frame(1'b0, PSI_OP_READ, MY_ADDR ^ 5'h01, PSI_ADDR_STATUS, 16'h0, rd);
        check("other address silent", 16'hffff, rd);
    endtask

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys_i);
        #1 reset_i = 1'b0;
        repeat (5) @(posedge clk_sys_i);
        t_reset_values();
        t_identity();
        t_remote_fault();
        t_jabber();
        t_link();
        t_write_ignored();
        t_bad_frame();
        close_out();
    end

    // Watchdog, about four times the expected run
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        err_total++;
        close_out();
    end
endmodule

// >>> test/psi_sta_model.sv
`timescale 1ns/1ps
module psi_sta_model
    import psi_pkg::*;
(
    input wire logic mdio_i,
    output logic mdc_o,
    output logic drv_o,
    output logic dat_o
);
    localparam realtime HALF = 62.5;

    // Idle: clock parked low, line released
    initial begin
        mdc_o = 1'b0;
        drv_o = 1'b0;
        dat_o = 1'b1;
    end

    // One whole frame with the normal write turnaround
    task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd);
        frame_ta(pre, op, pa, ra, 2'b10, wd, rd);
    endtask

    // One whole frame, optional 32-bit preamble, chosen turnaround, data msb first
    task automatic frame_ta(input logic pre, input logic [1:0] op, input logic [4:0] pa,
                            input logic [4:0] ra, input logic [1:0] ta,
                            input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] word;
        int n;
        begin
            word = {2'b01, op, pa, ra, ta, wd & 16'hf87f};
            n = pre ? 32 : 0;
            rd = 16'h0000;
            for (int i = 0; i < n + 32; i++) begin
                // Release the line for turnaround and read data
                drv_o = !(op == PSI_OP_READ && i >= n + 14);
                dat_o = (i < n) ? 1'b1 : word[31 - (i - n)];
                #(HALF);
                if (i >= n + 16) begin
                    rd = {rd[14:0], mdio_i};
                end
                mdc_o = 1'b1;
                #(HALF);
                mdc_o = 1'b0;
            end
            drv_o = 1'b0;
            #(4 * HALF);
        end
    endtask
endmodule
